/* hdl/tsp_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
module tsp_host_port #(
   parameter int ADDR_W = tsp_pkg::ADDR_W,
   parameter int LOW_W  = tsp_pkg::LOW_W,
   parameter int DATA_W = tsp_pkg::DATA_W
) (
   // System
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Device reset pin and mode straps
   input  wire logic              resetPinN,
   input  wire logic              busModeSelect,
   input  wire logic              strobeSeparate,
   // Host control
   input  wire logic              chipSelectN,
   input  wire logic              dataStrobe,
   input  wire logic              readWrite,
   input  wire logic              addrLatchStrobe,
   input  wire logic [ADDR_W-1:0] addrLines,
   // Shared address/data low byte
   input  wire logic [LOW_W-1:0]  sharedAddrDataLowIn,
   output logic [LOW_W-1:0]       sharedAddrDataLowOut,
   output logic                   sharedAddrDataLowOe,
   // Data high byte
   input  wire logic [LOW_W-1:0]  dataHighByteIn,
   output logic [LOW_W-1:0]       dataHighByteOut,
   output logic                   dataHighByteOe,
   // Transfer acknowledge
   output logic                   transferAckNOut,
   output logic                   transferAckNOe,
   // Serial transmit float control
   output logic                   serialOutStreamsHiZ
);
   if (ADDR_W != tsp_pkg::ADDR_W || LOW_W != tsp_pkg::LOW_W || DATA_W != 2 * LOW_W) begin : g_chk
      $error("tsp_host_port: unsupported width parameters");
   end

   tsp_pkg::tsp_regs_type st;
   tsp_pkg::tsp_regs_type next_st;

   tsp_mem_if #(.AW(ADDR_W), .DW(DATA_W)) memBus ();

   tsp_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
      .clk_sys (clk_sys),
      .mem     (memBus)
   );

   // Returns {read, write} for the current pin levels
   function automatic logic [1:0] decodeAccess(
      input logic muxMode,
      input logic sepStrobe,
      input logic csN,
      input logic ds,
      input logic rw
   );
      logic rd;
      logic wr;
      rd = 1'b0;
      wr = 1'b0;
      if (!csN) begin
         if (!muxMode) begin
            rd = !ds && rw;
            wr = !ds && !rw;
         end else if (sepStrobe) begin
            rd = !ds;
            wr = !rw && ds;
         end else begin
            rd = ds && rw;
            wr = ds && !rw;
         end
      end
      return {rd, wr};
   endfunction : decodeAccess

   logic [1:0]        access;
   logic              reqRead;
   logic              reqWrite;
   logic [ADDR_W-1:0] busAddr;

   always_comb begin
      access   = decodeAccess(busModeSelect, strobeSeparate, chipSelectN, dataStrobe, readWrite);
      reqRead  = access[1];
      reqWrite = access[0];
      // Latched address in multiplexed mode, dedicated lines otherwise
      busAddr  = busModeSelect ? st.addrLatch : addrLines;
   end

   always_comb begin
      next_st        = st;
      memBus.en      = 1'b0;
      memBus.we      = 1'b0;
      memBus.addr    = busAddr;
      memBus.wdata   = {dataHighByteIn, sharedAddrDataLowIn};
      next_st.txHiZ  = 1'b0;

      // Strobe is ignored outside multiplexed mode, where it is tied low
      if (busModeSelect && addrLatchStrobe) begin
         next_st.addrLatch = sharedAddrDataLowIn;
      end

      case (st.state)
         tsp_pkg::TSP_IDLE: begin
            if (reqRead || reqWrite) begin
               memBus.en      = 1'b1;
               memBus.we      = reqWrite;
               next_st.isRead = reqRead;
               next_st.state  = tsp_pkg::TSP_ACCESS;
            end
         end
         tsp_pkg::TSP_ACCESS: begin
            if (st.isRead) begin
               next_st.rdData = memBus.rdata;
               next_st.dataOe = 1'b1;
            end
            next_st.ackOut = tsp_pkg::ACK_ACTIVE;
            next_st.ackOe  = 1'b1;
            next_st.state  = tsp_pkg::TSP_ACK;
         end
         tsp_pkg::TSP_ACK: begin
            // Hold the answer until the host ends the cycle; a chip select
            // release ends it too, so a dropped cycle cannot hang the port
            if (!(reqRead || reqWrite)) begin
               next_st.dataOe = 1'b0;
               next_st.ackOut = tsp_pkg::ACK_INACTIVE;
               next_st.state  = tsp_pkg::TSP_RELEASE;
            end
         end
         tsp_pkg::TSP_RELEASE: begin
            // One cycle of driven high lets a weak pull-up keep the line
            next_st.ackOe = 1'b0;
            next_st.state = tsp_pkg::TSP_IDLE;
         end
         default: begin
            next_st = tsp_pkg::REGS_RESET;
         end
      endcase

      // Any sampled low level clears the port; the host keeps it long enough
      if (!resetPinN) begin
         next_st   = tsp_pkg::REGS_RESET;
         memBus.en = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st <= tsp_pkg::REGS_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign sharedAddrDataLowOut = st.rdData[LOW_W-1:0];
   assign dataHighByteOut      = st.rdData[DATA_W-1:LOW_W];
   assign sharedAddrDataLowOe  = st.dataOe;
   assign dataHighByteOe       = st.dataOe;
   assign transferAckNOut      = st.ackOut;
   assign transferAckNOe       = st.ackOe;
   assign serialOutStreamsHiZ  = st.txHiZ;
endmodule : tsp_host_port
`default_nettype wire

/* hdl/tsp_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module tsp_mem #(
   parameter int AW = tsp_pkg::ADDR_W,
   parameter int DW = tsp_pkg::DATA_W
) (
   // Clock
   input wire logic clk_sys,
   // Access port
   tsp_mem_if.store mem
);
   localparam int DEPTH = 1 << AW;

   // Contents survive reset; only the port logic is cleared
   logic [DW-1:0] store [DEPTH];
   logic [DW-1:0] rdata;

   always_ff @(posedge clk_sys) begin
      if (mem.en && mem.we) begin
         store[mem.addr] <= mem.wdata;
      end
      if (mem.en && !mem.we) begin
         rdata <= store[mem.addr];
      end
   end

   assign mem.rdata = rdata;
endmodule : tsp_mem
`default_nettype wire

/* hdl/tsp_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface tsp_mem_if #(
   parameter int AW = tsp_pkg::ADDR_W,
   parameter int DW = tsp_pkg::DATA_W
);
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctrl  (output en, output we, output addr, output wdata, input rdata);
   modport store (input en, input we, input addr, input wdata, output rdata);
endinterface : tsp_mem_if
`default_nettype wire

/* hdl/tsp_pkg.sv */
// Notes on behaviour
// - Reset pin low clears state and floats serial outputs and host data lines.
// - Non-multiplexed mode uses the eight address lines directly as memory address.
// - Multiplexed single-strobe mode: data strobe active high, qualified by chip select.
// - Non-multiplexed mode: data strobe active low, qualified by chip select.
// - Multiplexed separate-strobe mode: read strobe low drives all sixteen data lines.
// - Single-strobe styles: read/write input sets data bus direction.
// - Multiplexed separate-strobe mode: write strobe low with read strobe high makes the low lines inputs.
// - Chip select low activates the port; data strobe and read/write ignored while it is high, but the address latch strobe still latches.
// - Bus mode pin high selects multiplexed, low selects non-multiplexed operation.
// - Acknowledge goes low on completion, then high briefly, then released.
// - Address latch strobe used only in multiplexed mode; tied low otherwise.
package tsp_pkg;
   localparam int ADDR_W        = 8;
   localparam int LOW_W         = 8;
   localparam int DATA_W        = 16;
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESET_MIN_NS  = 100;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic ACK_ACTIVE   = 1'h0;
   localparam logic ACK_INACTIVE = 1'h1;

   typedef enum logic [1:0] {
      TSP_IDLE    = 2'h0,
      TSP_ACCESS  = 2'h1,
      TSP_ACK     = 2'h3,
      TSP_RELEASE = 2'h2
   } tsp_state_type;

   typedef struct packed {
      tsp_state_type       state;
      logic [ADDR_W-1:0]   addrLatch;
      logic [DATA_W-1:0]   rdData;
      logic                isRead;
      logic                dataOe;
      logic                ackOut;
      logic                ackOe;
      logic                txHiZ;
   } tsp_regs_type;

   localparam tsp_regs_type REGS_RESET = '{
      state:     TSP_IDLE,
      addrLatch: 8'h00,
      rdData:    16'h0000,
      isRead:    1'h0,
      dataOe:    1'h0,
      ackOut:    ACK_INACTIVE,
      ackOe:     1'h0,
      txHiZ:     1'h1
   };
endpackage : tsp_pkg

/* verification/tsp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tsp_host_model (
   // Device data pins
   input wire logic [7:0] lowOut,
   input wire logic [7:0] highOut,
   input wire logic       lowOe,
   input wire logic       highOe,
   // Device acknowledge pin
   input wire logic       ackOut,
   input wire logic       ackOe,
   // What the host sees
   output logic [15:0]    busSeen,
   output logic           ackLine
);
   // Pull-up holds the acknowledge wire high once released
   assign ackLine = ackOe ? ackOut : 1'h1;
   // Undriven bytes read inverted so a stale value can never pass
   assign busSeen = {highOe ? highOut : ~highOut, lowOe ? lowOut : ~lowOut};
endmodule : tsp_host_model
`default_nettype wire

/* verification/tsp_host_port_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tsp_host_port_sva (
   // System
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Device reset pin and mode straps
   input wire logic resetPinN,
   input wire logic busModeSelect,
   input wire logic strobeSeparate,
   // Host control
   input wire logic chipSelectN,
   input wire logic dataStrobe,
   input wire logic readWrite,
   // Device outputs
   input wire logic sharedAddrDataLowOe,
   input wire logic dataHighByteOe,
   input wire logic transferAckNOut,
   input wire logic transferAckNOe,
   input wire logic serialOutStreamsHiZ
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_RST_FLOAT: assert property (
      !resetPinN |=> !sharedAddrDataLowOe && !transferAckNOe && serialOutStreamsHiZ)
      else $error("reset pin did not float the port");
   AST_CS_IGNORE: assert property (chipSelectN [*3] |-> transferAckNOut)
      else $error("acknowledge low without chip select");
   AST_ACK_HIGH: assert property (
      $fell(transferAckNOe) && $past(resetPinN) |-> $past(transferAckNOut))
      else $error("acknowledge released without driving high first");
   AST_NONMUX_RD: assert property (
      (resetPinN && !busModeSelect && !chipSelectN && !dataStrobe && readWrite) [*3]
      |=> !transferAckNOut && sharedAddrDataLowOe) else $error("non-mux read not answered");
   AST_MUX_WR: assert property (
      (busModeSelect && !strobeSeparate && !chipSelectN && dataStrobe && !readWrite) [*3]
      |=> !transferAckNOut && !sharedAddrDataLowOe) else $error("mux write not answered");
   AST_SEP_RD: assert property (
      (busModeSelect && strobeSeparate && !chipSelectN && !dataStrobe && readWrite) [*3]
      |=> sharedAddrDataLowOe && dataHighByteOe) else $error("read strobe did not drive bus");
   AST_SEP_WR: assert property (
      (busModeSelect && strobeSeparate && !chipSelectN && dataStrobe && !readWrite) [*3]
      |=> !transferAckNOut && !sharedAddrDataLowOe) else $error("write strobe drove bus");
   AST_OE_PAIR: assert property (
      sharedAddrDataLowOe |-> dataHighByteOe && transferAckNOe && !transferAckNOut)
      else $error("data driven outside acknowledged read");
endmodule : tsp_host_port_sva
`default_nettype wire

/* verification/tsp_host_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tsp_host_port_tb;
   logic clk_sys = 0, sys_rst = 1, resetPinN = 1, busModeSelect = 0, strobeSeparate = 0;
   logic chipSelectN = 1, dataStrobe = 1, readWrite = 1, addrLatchStrobe = 0;
   logic [7:0] addrLines = 8'h00, lowIn = 8'h00, highIn = 8'h00, lowOut, highOut;
   logic lowOe, highOe, ackOut, ackOe, hiZ, ackLine;
   logic [15:0] busSeen, q;
   int num_errors = 0, checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   tsp_host_port dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .resetPinN(resetPinN),
      .busModeSelect(busModeSelect), .strobeSeparate(strobeSeparate),
      .chipSelectN(chipSelectN), .dataStrobe(dataStrobe), .readWrite(readWrite),
      .addrLatchStrobe(addrLatchStrobe), .addrLines(addrLines), .sharedAddrDataLowIn(lowIn),
      .sharedAddrDataLowOut(lowOut), .sharedAddrDataLowOe(lowOe), .dataHighByteIn(highIn),
      .dataHighByteOut(highOut), .dataHighByteOe(highOe), .transferAckNOut(ackOut),
      .transferAckNOe(ackOe), .serialOutStreamsHiZ(hiZ));
   tsp_host_model host_u (.lowOut(lowOut), .highOut(highOut), .lowOe(lowOe),
      .highOe(highOe), .ackOut(ackOut), .ackOe(ackOe), .busSeen(busSeen), .ackLine(ackLine));
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // Waits for {ackLine, ackOe}; a hang counts as a mismatch
   task automatic wait_ack(input logic [1:0] want);
      int i;
      for (i = 0; i < 12 && {ackLine, ackOe} !== want; i++) @(posedge clk_sys) #1;
      if (i == 12) begin
         num_errors++;
         report_and_stop();
      end
   endtask : wait_ack
   task automatic access(input logic m, s, r, input logic [7:0] a, input logic [15:0] w);
      busModeSelect = m;
      strobeSeparate = s;
      addrLines = a;
      lowIn = a;
      addrLatchStrobe = m;
      @(posedge clk_sys) #1;
      addrLatchStrobe = 0;
      addrLines = m ? ~a : a;
      {highIn, lowIn} = w;
      readWrite = r;
      dataStrobe = m ? (s ? !r : 1'h1) : 1'h0;
      chipSelectN = 0;
      wait_ack(2'b01);
      // Hold one more cycle so the answer is seen to stand while the strobe does
      @(posedge clk_sys) #1;
      q = busSeen;
      chipSelectN = 1;
      readWrite = 1;
      dataStrobe = !(m && !s);
      wait_ack(2'b10);
   endtask : access
   task automatic t_modes;
      access(0, 0, 0, 8'h3C, 16'hA55A);
      access(0, 0, 1, 8'h3C, 16'h0000);
      check("nonmux word", q, 16'hA55A);
      access(1, 0, 0, 8'hC3, 16'h1234);
      access(0, 0, 1, 8'hC3, 16'h0000);
      check("mux to nonmux word", q, 16'h1234);
      access(1, 0, 1, 8'hC3, 16'h0000);
      check("mux single read", q, 16'h1234);
      access(1, 1, 0, 8'h81, 16'hBEEF);
      access(1, 1, 1, 8'h81, 16'h0000);
      check("split strobe word", q, 16'hBEEF);
      $display("%m done");
   endtask : t_modes
   task automatic t_cs_high;
      {busModeSelect, dataStrobe, readWrite} = 3'b000;
      {highIn, lowIn} = 16'h0F0F;
      addrLines = 8'h3C;
      repeat (6) @(posedge clk_sys) #1;
      check("ack with cs high", ackLine, 1'h1);
      dataStrobe = 1;
      access(0, 0, 1, 8'h3C, 16'h0000);
      check("word after cs high", q, 16'hA55A);
      $display("%m done");
   endtask : t_cs_high
   task automatic t_reset_pin;
      {busModeSelect, dataStrobe, readWrite, chipSelectN} = 4'b0010;
      wait_ack(2'b01);
      resetPinN = 0;
      repeat (tsp_pkg::RESET_MIN_CYC) @(posedge clk_sys) #1;
      check("floated pins", {lowOe, highOe, ackOe, hiZ}, 4'b0001);
      chipSelectN = 1;
      resetPinN = 1;
      repeat (3) @(posedge clk_sys) #1;
      check("serial enabled", hiZ, 1'h0);
      $display("%m done");
   endtask : t_reset_pin
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 sys_rst = 0;
      t_modes();
      t_cs_high();
      t_reset_pin();
      report_and_stop();
   end
endmodule : tsp_host_port_tb
bind tsp_host_port tsp_host_port_sva chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .resetPinN(resetPinN), .busModeSelect(busModeSelect), .strobeSeparate(strobeSeparate),
   .chipSelectN(chipSelectN), .dataStrobe(dataStrobe), .readWrite(readWrite),
   .sharedAddrDataLowOe(sharedAddrDataLowOe), .dataHighByteOe(dataHighByteOe),
   .transferAckNOut(transferAckNOut), .transferAckNOe(transferAckNOe),
   .serialOutStreamsHiZ(serialOutStreamsHiZ));
`default_nettype wire
